// ### core/adcsl_regs.sv
// Status, protection key, align and latch control, slot enable and revision register bank.
//
// Functional notes
// RULE1: The reset-progress flag in primary status bit 0 reads one during reset and clears once the bank is ready.
// RULE2: The checksum-changed flag in primary status bit 1 sets whenever the configuration checksum changes value.
// RULE3: Primary status bit 2 reads zero while unprotected and one after the lock key has been written.
// RULE4: Writing 0xca to the key register enables protection and writing 0x9c disables it.
// RULE5: The key register is write-only and reads back as 0x00.
// RULE6: A broadcast write of align bit 0 makes every device produce its outputs at the same instant.
// RULE7: A broadcast write of latch bit 1 makes every device latch its internal counter.
// RULE8: Both align and latch bits return to zero one input clock cycle after being set.
// RULE9: Bit n of the slot enable register gates the converter pulse in slot n of the divided clock; all reset to one.
// RULE10: Secondary status bits 2:0 hold a read-only three-bit revision number.
// RULE11: The missed-sample flag in secondary status bit 3 sets when a whole output period passes unread.
// RULE12: Any read of the secondary status register clears the missed-sample flag. The code keeps it set when a missed period closes in the same cycle.
// RULE13: Primary status bits 7:3 read zero and do nothing.
// RULE14: The counter value taken at a latch event is readable in bits 11:0 of the snapshot register.
// RULE15: Writes to configuration registers are ignored while protection is on, until the unlock key is written.
module adcsl_regs
  import adcsl_pkg::*;
#(
  parameter int INIT_CYCLES = ADCSL_INIT_CYCLES,
  parameter logic [2:0] REVISION = 3'h5, // Arbitrary value.
  parameter int SLOT_DIV = ADCSL_SLOT_DIV
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register access port.
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [4:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  // Converter side.
  input wire logic [15:0] cfg_checksum,
  input wire logic [11:0] sample_counter,
  input wire logic sample_strobe,
  input wire logic sample_read,
  // Control outputs.
  output logic align_pulse,
  output logic latch_pulse,
  output logic config_protected,
  output logic config_write_allowed,
  output logic converter_pulse_gate,
  output logic reset_busy
);
  generate
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
      $error("adcsl_regs: INIT_CYCLES must lie in 1..65535");
    end
  endgenerate

  adcsl_side_if side ();

  // Slot gate and missed-sample monitor.
  adcsl_slot_gate #(
    .DIV(SLOT_DIV)
  ) u_slot (
    .core_clk(core_clk),
    .rst(rst),
    .side(side.slot)
  );

  adcsl_miss_mon u_mon (
    .core_clk(core_clk),
    .rst(rst),
    .side(side.mon)
  );

  // Reset-progress state.
  adcsl_init_e init_reg;
  adcsl_init_e init_next;
  logic [15:0] init_cnt_reg;
  logic [15:0] init_cnt_next;

  // Register state.
  logic protected_reg;
  logic protected_next;
  logic checksum_changed_reg;
  logic checksum_changed_next;
  logic [15:0] checksum_prev_reg;
  logic [15:0] checksum_prev_next;
  logic checksum_valid_reg;
  logic checksum_valid_next;
  logic align_reg;
  logic align_next;
  logic latch_reg;
  logic latch_next;
  logic [11:0] snapshot_reg;
  logic [11:0] snapshot_next;
  logic [7:0] slot_enables_reg;
  logic [7:0] slot_enables_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic gate_out_reg;
  logic busy_out_reg;
  logic allowed_out_reg;

  // Decoded accesses.
  logic wr_key;
  logic wr_align;
  logic wr_slots;
  logic rd_primary;
  logic rd_secondary;
  logic [7:0] primary_status;
  logic [7:0] secondary_status;

  // Address decode for writes and reads.
  always_comb begin
    wr_key = acc_wr && (acc_addr == ADCSL_OFS_PROTECTION_KEY);
    wr_align = acc_wr && (acc_addr == ADCSL_OFS_ALIGN_LATCH);
    wr_slots = acc_wr && (acc_addr == ADCSL_OFS_SLOT_ENABLES);
    rd_primary = acc_rd && (acc_addr == ADCSL_OFS_PRIMARY_STATUS);
    rd_secondary = acc_rd && (acc_addr == ADCSL_OFS_SECONDARY_STATUS);
  end

  // Hold the reset-progress flag for INIT_CYCLES after reset release, then report ready.
  always_comb begin
    init_next = init_reg;
    init_cnt_next = init_cnt_reg;
    case (init_reg)
      ADCSL_ST_BUSY: begin
        if (init_cnt_reg == 16'(INIT_CYCLES - 1)) begin
          init_next = ADCSL_ST_READY; // [RULE1]
        end else begin
          init_cnt_next = init_cnt_reg + 16'h0001;
        end
      end
      ADCSL_ST_READY: begin
        init_next = ADCSL_ST_READY;
      end
      default: begin
        init_next = ADCSL_ST_BUSY;
        init_cnt_next = 16'h0000;
      end
    endcase
  end

  // Register the reset-progress state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_reg <= ADCSL_ST_BUSY; // [RULE1]
      init_cnt_reg <= 16'h0000;
    end else begin
      init_reg <= init_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  // Lock key decode; any value other than the two keys leaves protection as it is.
  always_comb begin
    protected_next = protected_reg;
    if (wr_key && acc_wdata == ADCSL_KEY_LOCK) begin
      protected_next = 1'b1; // [RULE4]
    end else if (wr_key && acc_wdata == ADCSL_KEY_UNLOCK) begin
      protected_next = 1'b0; // [RULE4]
    end
  end

  // Track the configuration checksum and raise the sticky flag on any change; the set wins over a read clear.
  always_comb begin
    checksum_prev_next = cfg_checksum;
    checksum_valid_next = 1'b1;
    checksum_changed_next = checksum_changed_reg;
    if (rd_primary) begin
      checksum_changed_next = 1'b0;
    end
    if (checksum_valid_reg && cfg_checksum != checksum_prev_reg) begin
      checksum_changed_next = 1'b1; // [RULE2]
    end
  end

  // Align and latch bits set on a write and drop back on the next cycle.
  always_comb begin
    align_next = wr_align && acc_wdata[ADCSL_ALC_ALIGN_BIT]; // [RULE6] [RULE8]
    latch_next = wr_align && acc_wdata[ADCSL_ALC_LATCH_BIT]; // [RULE7] [RULE8]
    snapshot_next = snapshot_reg;
    if (latch_next) begin
      snapshot_next = sample_counter; // [RULE14]
    end
  end

  // Slot enables accept writes only while configuration is unprotected.
  always_comb begin
    slot_enables_next = slot_enables_reg;
    if (wr_slots && !protected_reg) begin
      slot_enables_next = acc_wdata; // [RULE15]
    end
  end

  // Assemble the two status bytes.
  always_comb begin
    primary_status = 8'h00; // [RULE13]
    primary_status[ADCSL_PST_RESET_BUSY_BIT] = (init_reg != ADCSL_ST_READY); // [RULE1]
    primary_status[ADCSL_PST_CHECKSUM_CHANGED_BIT] = checksum_changed_reg;
    primary_status[ADCSL_PST_PROTECTED_BIT] = protected_reg; // [RULE3]
    secondary_status = 8'h00;
    secondary_status[ADCSL_SST_REVISION_LSB +: 3] = REVISION; // [RULE10]
    secondary_status[ADCSL_SST_SAMPLE_MISSED_BIT] = side.sample_missed; // [RULE11]
  end

  // Read multiplexer; unmapped and write-only addresses answer zero.
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = acc_rd;
    if (acc_rd) begin
      case (acc_addr)
        ADCSL_OFS_SNAPSHOT: rdata_next = {4'h0, snapshot_reg}; // [RULE14]
        ADCSL_OFS_PRIMARY_STATUS: rdata_next = {8'h00, primary_status};
        ADCSL_OFS_PROTECTION_KEY: rdata_next = {8'h00, ADCSL_KEY_READBACK}; // [RULE5]
        ADCSL_OFS_ALIGN_LATCH: rdata_next = {14'h0, latch_reg, align_reg};
        ADCSL_OFS_SLOT_ENABLES: rdata_next = {8'h00, slot_enables_reg};
        ADCSL_OFS_SECONDARY_STATUS: rdata_next = {8'h00, secondary_status};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // Register the protection state; it comes out of reset unprotected.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      protected_reg <= 1'b0;
    end else begin
      protected_reg <= protected_next;
    end
  end

  // Register the checksum tracker; the first sample after reset only primes the compare.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      checksum_changed_reg <= 1'b0;
      checksum_prev_reg <= 16'h0000;
      checksum_valid_reg <= 1'b0;
    end else begin
      checksum_changed_reg <= checksum_changed_next;
      checksum_prev_reg <= checksum_prev_next;
      checksum_valid_reg <= checksum_valid_next;
    end
  end

  // Register the align and latch pulses and the counter snapshot.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      align_reg <= 1'b0;
      latch_reg <= 1'b0;
      snapshot_reg <= ADCSL_SNAPSHOT_RESET;
    end else begin
      align_reg <= align_next;
      latch_reg <= latch_next;
      snapshot_reg <= snapshot_next;
    end
  end

  // Register the slot enables; every slot is enabled out of reset.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_enables_reg <= ADCSL_SLOT_ENABLES_RESET; // [RULE9]
    end else begin
      slot_enables_reg <= slot_enables_next;
    end
  end

  // Register the read answer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= ADCSL_RDATA_RESET;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Output flops for values that come from combinational terms or the submodules.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gate_out_reg <= 1'b0;
      busy_out_reg <= 1'b1;
      allowed_out_reg <= 1'b1;
    end else begin
      gate_out_reg <= side.pulse_gate; // [RULE9]
      busy_out_reg <= (init_next != ADCSL_ST_READY);
      allowed_out_reg <= !protected_next; // [RULE15]
    end
  end

  // Signals to the submodules.
  assign side.slot_enables = slot_enables_reg;
  assign side.sample_strobe = sample_strobe;
  assign side.sample_read = sample_read;
  assign side.status_read = rd_secondary; // [RULE12]

  // Top-level outputs, each straight from a flip-flop.
  assign acc_rdata = rdata_reg;
  assign acc_rvalid = rvalid_reg;
  assign align_pulse = align_reg;
  assign latch_pulse = latch_reg;
  assign config_protected = protected_reg;
  assign config_write_allowed = allowed_out_reg;
  assign converter_pulse_gate = gate_out_reg;
  assign reset_busy = busy_out_reg;
endmodule : adcsl_regs

// ### core/adcsl_pkg.sv
// Package with register map, field positions, reset values and timing counts for the status and lock bank.
package adcsl_pkg;
  // Register offsets on the register access port.
  localparam logic [4:0] ADCSL_OFS_SNAPSHOT = 5'h07;
  localparam logic [4:0] ADCSL_OFS_PRIMARY_STATUS = 5'h09;
  localparam logic [4:0] ADCSL_OFS_PROTECTION_KEY = 5'h0a;
  localparam logic [4:0] ADCSL_OFS_ALIGN_LATCH = 5'h0b;
  localparam logic [4:0] ADCSL_OFS_SLOT_ENABLES = 5'h0e;
  localparam logic [4:0] ADCSL_OFS_SECONDARY_STATUS = 5'h0f;

  // Primary status field positions.
  localparam int ADCSL_PST_RESET_BUSY_BIT = 0;
  localparam int ADCSL_PST_CHECKSUM_CHANGED_BIT = 1;
  localparam int ADCSL_PST_PROTECTED_BIT = 2;

  // Align and latch control field positions.
  localparam int ADCSL_ALC_ALIGN_BIT = 0;
  localparam int ADCSL_ALC_LATCH_BIT = 1;

  // Secondary status field positions.
  localparam int ADCSL_SST_REVISION_LSB = 0;
  localparam int ADCSL_SST_SAMPLE_MISSED_BIT = 3;

  // Key values.
  localparam logic [7:0] ADCSL_KEY_LOCK = 8'hca;
  localparam logic [7:0] ADCSL_KEY_UNLOCK = 8'h9c;
  localparam logic [7:0] ADCSL_KEY_READBACK = 8'h00;

  // Reset values.
  localparam logic [7:0] ADCSL_SLOT_ENABLES_RESET = 8'hff;
  localparam logic [11:0] ADCSL_SNAPSHOT_RESET = 12'h000;
  localparam logic [15:0] ADCSL_RDATA_RESET = 16'h0000;

  // Widths.
  localparam int ADCSL_COUNTER_W = 12;
  localparam int ADCSL_DATA_W = 16;
  localparam int ADCSL_SLOT_N = 8;

  // Input clock divider that forms one converter slot.
  localparam int ADCSL_SLOT_DIV = 4;

  // Cycles that the reset-progress flag stays set after reset release.
  localparam int ADCSL_INIT_CYCLES = 64;

  // Reset-progress states, one-hot.
  typedef enum logic [1:0] {
    ADCSL_ST_BUSY = 2'b01,
    ADCSL_ST_READY = 2'b10
  } adcsl_init_e;
endpackage : adcsl_pkg

// ### core/adcsl_side_if.sv
// Interface joining the register bank to its slot gate and missed-sample monitor.
interface adcsl_side_if;
  logic [7:0] slot_enables;
  logic pulse_gate;
  logic sample_strobe;
  logic sample_read;
  logic status_read;
  logic sample_missed;

  modport bank (output slot_enables, output sample_strobe, output sample_read, output status_read,
                input pulse_gate, input sample_missed);
  modport slot (input slot_enables, output pulse_gate);
  modport mon (input sample_strobe, input sample_read, input status_read, output sample_missed);
endinterface : adcsl_side_if

// ### core/adcsl_slot_gate.sv
// Converter pulse gate stepping through eight slots of the divided input clock.
module adcsl_slot_gate
  import adcsl_pkg::*;
#(
  parameter int DIV = ADCSL_SLOT_DIV
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bank side.
  adcsl_side_if.slot side
);
  generate
    if (DIV < 2 || DIV > 256) begin : g_bad_div
      $error("adcsl_slot_gate: DIV must lie in 2..256");
    end
  endgenerate

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [2:0] slot_reg;
  logic [2:0] slot_next;
  logic gate_reg;
  logic gate_next;

  // Divide the clock by DIV and step the slot index at the end of each divided period.
  always_comb begin
    div_next = div_reg + 8'h01;
    slot_next = slot_reg;
    if (div_reg == 8'(DIV - 1)) begin
      div_next = 8'h00;
      slot_next = slot_reg + 3'h1;
    end
    gate_next = side.slot_enables[slot_next]; // [RULE9]
  end

  // Register divider, slot and gate.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
      slot_reg <= 3'h0;
      gate_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      slot_reg <= slot_next;
      gate_reg <= gate_next;
    end
  end

  assign side.pulse_gate = gate_reg;
endmodule : adcsl_slot_gate

// ### core/adcsl_miss_mon.sv
// Monitor that flags an output period in which no converter output was read.
module adcsl_miss_mon
  import adcsl_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Bank side.
  adcsl_side_if.mon side
);
  logic read_seen_reg;
  logic read_seen_next;
  logic armed_reg;
  logic armed_next;
  logic missed_reg;
  logic missed_next;
  logic period_missed;

  // A new output closes the previous period; it counts as missed when nothing read it.
  always_comb begin
    period_missed = side.sample_strobe && armed_reg && !read_seen_reg && !side.sample_read;
    read_seen_next = read_seen_reg || side.sample_read;
    armed_next = armed_reg;
    if (side.sample_strobe) begin
      read_seen_next = 1'b0;
      armed_next = 1'b1;
    end
    missed_next = missed_reg;
    if (side.status_read) begin
      missed_next = 1'b0; // [RULE12]
    end
    if (period_missed) begin
      missed_next = 1'b1; // [RULE11]
    end
  end

  // Register the monitor state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      read_seen_reg <= 1'b0;
      armed_reg <= 1'b0;
      missed_reg <= 1'b0;
    end else begin
      read_seen_reg <= read_seen_next;
      armed_reg <= armed_next;
      missed_reg <= missed_next;
    end
  end

  assign side.sample_missed = missed_reg;
endmodule : adcsl_miss_mon

// ### verif/adcsl_regs_props.sv
// Concurrent checks on the ports of the status and lock register bank.
module adcsl_regs_props
  import adcsl_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h5
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register access port.
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [4:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid,
  // Control outputs.
  input wire logic align_pulse,
  input wire logic latch_pulse,
  input wire logic config_protected,
  input wire logic config_write_allowed,
  input wire logic reset_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Access events that the checks start from.
  sequence rd_at(logic [4:0] a);
    acc_rd && acc_addr == a;
  endsequence
  sequence key_wr(logic [7:0] k);
    acc_wr && acc_addr == ADCSL_OFS_PROTECTION_KEY && acc_wdata == k;
  endsequence
  sequence ctl_wr(int b);
    acc_wr && acc_addr == ADCSL_OFS_ALIGN_LATCH && acc_wdata[b];
  endsequence
  // A pulse that stands for exactly one cycle.
  sequence pulse_once(s);
    s ##1 !s;
  endsequence

  // Status, key, pulse and revision relations.
  busy_flag_a: assert property (rd_at(ADCSL_OFS_PRIMARY_STATUS) |=> acc_rdata[0] == $past(reset_busy))
    else $error("busy flag differs from reset state");
  prot_flag_a: assert property (rd_at(ADCSL_OFS_PRIMARY_STATUS) |=> acc_rdata[2] == $past(config_protected))
    else $error("protection flag differs from state");
  status_upper_a: assert property (rd_at(ADCSL_OFS_PRIMARY_STATUS) |=> acc_rdata[15:3] == 13'h0)
    else $error("unused status bits not zero");
  lock_key_a: assert property (key_wr(ADCSL_KEY_LOCK) |=> config_protected)
    else $error("lock key did not protect");
  unlock_key_a: assert property (key_wr(ADCSL_KEY_UNLOCK) |=> !config_protected)
    else $error("unlock key did not unprotect");
  key_other_a: assert property (acc_wr && acc_addr == ADCSL_OFS_PROTECTION_KEY && acc_wdata != ADCSL_KEY_LOCK
    && acc_wdata != ADCSL_KEY_UNLOCK |=> $stable(config_protected))
    else $error("other key value changed protection");
  key_read_a: assert property (rd_at(ADCSL_OFS_PROTECTION_KEY) |=> acc_rvalid && acc_rdata == 16'h0)
    else $error("key register did not read zero");
  align_once_a: assert property (ctl_wr(ADCSL_ALC_ALIGN_BIT) |=> pulse_once(align_pulse))
    else $error("align pulse not single cycle");
  latch_once_a: assert property (ctl_wr(ADCSL_ALC_LATCH_BIT) |=> pulse_once(latch_pulse))
    else $error("latch pulse not single cycle");
  revision_a: assert property (rd_at(ADCSL_OFS_SECONDARY_STATUS) |=> acc_rdata[2:0] == REVISION)
    else $error("revision field wrong");
  write_allow_a: assert property (config_write_allowed == !config_protected)
    else $error("write permission disagrees with protection");
endmodule : adcsl_regs_props

bind adcsl_regs adcsl_regs_props #(.REVISION(REVISION)) u_props (
  .core_clk(core_clk), .rst(rst), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
  .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .align_pulse(align_pulse),
  .latch_pulse(latch_pulse), .config_protected(config_protected),
  .config_write_allowed(config_write_allowed), .reset_busy(reset_busy)
);

// ### verif/adcsl_host_model.sv
// Host model that drives the register access port one request at a time.
module adcsl_host_model (
  // Clock.
  input wire logic core_clk,
  // Register access port.
  output logic acc_wr,
  output logic acc_rd,
  output logic [4:0] acc_addr,
  output logic [7:0] acc_wdata,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port at time zero.
  initial begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = 5'h00;
    acc_wdata = 8'h00;
  end

  // One-cycle write; released lines take inverted values so stale data is never mistaken for valid.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    acc_wr = 1'b1;
    acc_addr = a;
    acc_wdata = d;
    @(posedge core_clk) #1;
    acc_wr = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask : wr

  // One-cycle read, then a bounded wait for the valid strobe.
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output bit ok);
    @(posedge core_clk) #1;
    acc_rd = 1'b1;
    acc_addr = a;
    @(posedge core_clk) #1;
    acc_rd = 1'b0;
    acc_addr = ~a;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (acc_rvalid === 1'b1) begin
        ok = 1'b1;
      end else begin
        @(posedge core_clk) #1;
      end
    end
    d = acc_rdata;
  endtask : rd
endmodule : adcsl_host_model

// ### verif/adc_status_lock_sync_regs_test.sv
// Self-checking bench for the status and lock register bank.
`define CHK(g, e) check_eq(16'(g), 16'(e))
module adc_status_lock_sync_regs_test
  import adcsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [2:0] REV = 3'h3; // Arbitrary value.

  // Clock, reset and converter-side stimulus.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] cfg_checksum = 16'h1234;
  logic [11:0] sample_counter = 12'h000;
  logic sample_strobe = 1'b0;
  logic sample_read = 1'b0;
  logic acc_wr, acc_rd, acc_rvalid, align_pulse, latch_pulse, config_protected;
  logic config_write_allowed, converter_pulse_gate, reset_busy;
  logic [4:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [15:0] acc_rdata;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #2 core_clk = ~core_clk;

  // Design and host.
  adcsl_regs #(.INIT_CYCLES(4), .REVISION(REV), .SLOT_DIV(4)) DUT (
    .core_clk(core_clk), .rst(rst), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .cfg_checksum(cfg_checksum),
    .sample_counter(sample_counter), .sample_strobe(sample_strobe), .sample_read(sample_read),
    .align_pulse(align_pulse), .latch_pulse(latch_pulse), .config_protected(config_protected),
    .config_write_allowed(config_write_allowed), .converter_pulse_gate(converter_pulse_gate),
    .reset_busy(reset_busy));
  adcsl_host_model host (.core_clk(core_clk), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

  // Compares two values and counts the result.
  task automatic check_eq(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : check_eq

  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // Reads a register and compares it; a read that never answers ends the run.
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      give_verdict();
    end else begin
      `CHK(d, e);
    end
  endtask : rc

  // One output period boundary, optionally with a sample read in the same cycle.
  task automatic strobe(input logic with_read);
    @(posedge core_clk) #1;
    sample_strobe = 1'b1;
    sample_read = with_read;
    @(posedge core_clk) #1;
    sample_strobe = 1'b0;
    sample_read = 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : strobe

  // Counts gated cycles over one full turn of eight slots.
  task automatic gate_cnt(input logic [15:0] e);
    logic [15:0] n;
    n = 16'h0;
    repeat (8) @(posedge core_clk);
    repeat (32) begin
      @(posedge core_clk) #1;
      n = n + 16'(converter_pulse_gate);
    end
    `CHK(n, e);
  endtask : gate_cnt

  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    `CHK(reset_busy, 1'b1);
    #1;
    rst = 1'b0;
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0001);
    repeat (8) @(posedge core_clk);
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0000);
    rc(ADCSL_OFS_SLOT_ENABLES, 16'h00ff);
    rc(ADCSL_OFS_PROTECTION_KEY, 16'h0000);
    rc(ADCSL_OFS_SECONDARY_STATUS, {13'h0, REV});
    rc(5'h1f, 16'h0000);
    gate_cnt(16'd32);
    host.wr(ADCSL_OFS_PROTECTION_KEY, ADCSL_KEY_LOCK);
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0004);
    host.wr(ADCSL_OFS_SLOT_ENABLES, 8'h0f);
    rc(ADCSL_OFS_SLOT_ENABLES, 16'h00ff);
    host.wr(ADCSL_OFS_PROTECTION_KEY, 8'h55);
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0004);
    host.wr(ADCSL_OFS_PROTECTION_KEY, ADCSL_KEY_UNLOCK);
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0000);
    host.wr(ADCSL_OFS_SLOT_ENABLES, 8'h0f);
    rc(ADCSL_OFS_SLOT_ENABLES, 16'h000f);
    gate_cnt(16'd16);
    host.wr(ADCSL_OFS_SLOT_ENABLES, 8'h01);
    gate_cnt(16'd4);
    cfg_checksum = 16'h4321;
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0002);
    rc(ADCSL_OFS_PRIMARY_STATUS, 16'h0000);
    sample_counter = 12'habc;
    host.wr(ADCSL_OFS_ALIGN_LATCH, 8'h03);
    rc(ADCSL_OFS_ALIGN_LATCH, 16'h0000);
    rc(ADCSL_OFS_SNAPSHOT, 16'h0abc);
    strobe(1'b0);
    strobe(1'b0);
    rc(ADCSL_OFS_SECONDARY_STATUS, {12'h0, 1'b1, REV});
    rc(ADCSL_OFS_SECONDARY_STATUS, {13'h0, REV});
    strobe(1'b1);
    rc(ADCSL_OFS_SECONDARY_STATUS, {13'h0, REV});
    give_verdict();
  end
endmodule : adc_status_lock_sync_regs_test
